//--- verilog/bep_pkg.sv
package bep_pkg;

	// endpoint capability reported to the host
	localparam logic [11:0] BEP_PAYLOAD_UNIT   = 12'h200;  // payload granule, 512 bytes
	localparam logic [2:0]  BEP_MAX_UNITS      = 3'h7;     // 7 granules, 3584 bytes
	localparam logic [11:0] BEP_MAX_PAYLOAD    = 12'hE00;  // largest_payload_field reset value
	localparam logic [4:0]  BEP_MAX_BURST      = 5'h10;    // packets per data phase
	localparam logic [4:0]  BEP_MAX_SEQ        = 5'h10;    // sequence numbers below this
	localparam logic        BEP_SIZE_ADJUST    = 1'b1;     // packet size adjustment offered
	localparam logic [3:0]  BEP_RATE_MASK      = 4'hF;     // supported signaling rates
	localparam logic [31:0] BEP_RESET_COUNT    = 32'h0000_0000;

	// register byte addresses
	localparam logic [7:0] BEP_REG_CTRL   = 8'h00;  // direction, ready, window init, forced halt
	localparam logic [7:0] BEP_REG_STATUS = 8'h04;  // pipe state
	localparam logic [7:0] BEP_REG_XFER   = 8'h08;  // expected transfer length
	localparam logic [7:0] BEP_REG_DONE   = 8'h0C;  // bytes moved so far
	localparam logic [7:0] BEP_REG_CAPS   = 8'h10;  // reported capability
	localparam logic [7:0] BEP_REG_BUFLVL = 8'h14;  // data or space available

	// control field positions
	localparam int BEP_CTRL_DIR_IN  = 0;   // 1 = IN endpoint, 0 = OUT
	localparam int BEP_CTRL_READY   = 1;   // client has data or space
	localparam int BEP_CTRL_INIT    = 2;   // window init strobe
	localparam int BEP_CTRL_STALL   = 3;   // force halt

	// pipe states
	typedef enum logic [3:0] {
		BEP_ST_IDLE   = 4'b0001,
		BEP_ST_BURST  = 4'b0010,
		BEP_ST_FLOW   = 4'b0100,
		BEP_ST_HALT   = 4'b1000
	} bep_state_t;

endpackage : bep_pkg

//--- verilog/bep_size_check.sv
`timescale 1ns/1ns
// checks a host-chosen packet size against the reported maximum
module bep_size_check
	import bep_pkg::*;
(
	input  wire logic [11:0] size_req,
	input  wire logic [11:0] size_max,
	input  wire logic        adjust_ok,
	output logic             size_legal
);
	logic granule_ok;  // whole multiple of the payload unit
	logic nonzero;     // at least one granule

	// with adjustment, sizes are multiples of 512 from one unit to the maximum
	always_comb begin
		granule_ok = (size_req[8:0] == 9'h000);
		nonzero    = (size_req != 12'h000);
		if (adjust_ok) begin
			size_legal = granule_ok && nonzero && (size_req <= size_max);
		end else begin
			// without adjustment only the reported maximum is valid
			size_legal = (size_req == size_max);
		end
	end
endmodule : bep_size_check

//--- verilog/bep_byte_count.sv
`timescale 1ns/1ns
// accumulates bytes moved and flags completion at the expected length
module bep_byte_count
	import bep_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        clear,
	input  wire logic        add,
	input  wire logic [11:0] add_len,
	input  wire logic [31:0] expected,
	output logic [31:0]      count_q,
	output logic             reached
);
	logic [31:0] count_d;  // next running total

	always_comb begin
		count_d = count_q + {20'h00000, add_len};
	end

	// running total, cleared per transfer
	always_ff @(posedge clk_sys) begin
		if (reset || clear) begin
			count_q <= BEP_RESET_COUNT;
		end else if (add) begin
			count_q <= count_d;
		end
	end

	// completion when this packet lands exactly on the expected count
	always_comb begin
		reached = add && (count_d == expected);
	end
endmodule : bep_byte_count

//--- verilog/bep_bulk_endpoint.sv
`timescale 1ns/1ns
// Operation
// - max payload is 512 multiple, 512..3584
// - max burst is between 1 and 16
// - IN packets use host-directed rate
// - IN token size is obeyed by endpoint
// - OUT accepts any valid active size
// - packets full active size except last
// - transfer ends on count or last flag
// - send ready notice when data/space exists
// - config requests reset window state
// - stall or retry exhaustion halts pipe; the stall bit is only seen in the idle state, and retry exhaustion in the flow state is ignored
// - each pipe carries one direction only
module bep_bulk_endpoint
	import bep_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// data_slot_token from the host
	input  wire logic        tok_valid,
	input  wire logic        tok_in,
	input  wire logic [11:0] tok_size,
	input  wire logic [4:0]  tok_burst,
	input  wire logic [3:0]  tok_rate,
	input  wire logic        cfg_request_ok,
	input  wire logic        retry_exhausted,
	// packets received on OUT
	input  wire logic        rx_valid,
	input  wire logic [11:0] rx_len,
	input  wire logic        rx_last_flag,
	// packets sent on IN
	input  wire logic        tx_ready,
	output logic             tx_valid,
	output logic [11:0]      tx_len,
	output logic             tx_last_flag,
	output logic [3:0]       tx_rate,
	// handshakes and notices
	output logic             hs_stall,
	output logic             hs_flow_ctrl,
	output logic             ep_ready_note,
	output logic             xfer_done
);
	bep_state_t  state_q;          // pipe state
	logic [31:0] ctrl_q;           // control register
	logic [31:0] xfer_len_q;       // expected transfer length
	logic [31:0] buf_lvl_q;        // bytes of data or space available
	logic [11:0] active_size_q;    // size fixed for this burst
	logic [4:0]  burst_left_q;     // packets remaining in burst
	logic [4:0]  seq_q;            // next sequence number
	logic [3:0]  rate_q;           // directed signaling rate
	logic        flow_note_q;      // ready notice still owed
	logic [31:0] sent_q;           // bytes issued on IN
	logic [31:0] moved;            // bytes moved this transfer
	logic        count_hit;        // expected count reached
	logic        size_ok;          // token size is legal
	logic        rate_ok;          // token rate is supported
	logic        tok_accept;       // token taken for a burst
	logic        pkt_move;         // one packet moved
	logic [11:0] pkt_len;          // its length
	logic        pkt_last;         // last flag of that packet
	logic [31:0] remain;           // bytes left to send
	logic        wr_en;            // apb write strobe
	logic        rd_hit;           // apb address mapped
	logic [31:0] caps_word;        // packed capability
	logic        win_init;         // sequence window back to its start

	// capability constants visible to software
	// layout: adjust bit, rate mask, sequence limit, burst limit, payload granules
	always_comb begin
		caps_word = {7'h00, BEP_SIZE_ADJUST, BEP_RATE_MASK, 3'h0, BEP_MAX_SEQ,
			BEP_MAX_BURST, BEP_MAX_PAYLOAD[11:9], 4'h0};
	end

	// token legality checker; undefined tokens are simply refused
	bep_size_check u_size (
		.size_req   (tok_size),
		.size_max   (BEP_MAX_PAYLOAD),
		.adjust_ok  (BEP_SIZE_ADJUST),
		.size_legal (size_ok)
	);

	// only rate indexes 0 to 3 exist; any upper bit set means an unknown rate
	always_comb begin
		rate_ok    = |(BEP_RATE_MASK & (4'h1 << tok_rate[1:0])) && (tok_rate[3:2] == 2'h0);
		// illegal tokens start no burst: the host's choice is undefined there
		// direction must match the pipe; an IN pipe ignores OUT tokens
		tok_accept = tok_valid && (state_q == BEP_ST_IDLE)
			&& (tok_in == ctrl_q[BEP_CTRL_DIR_IN])
			&& size_ok && rate_ok
			&& (tok_burst != 5'h00) && (tok_burst <= BEP_MAX_BURST);
	end

	// bytes still to send on the IN side
	// the full expected length between transfers; only the burst state raises tx_valid
	always_comb begin
		remain = xfer_len_q - sent_q;
	end

	// IN packet sizing: full active size unless remainder is smaller
	// compared on all 32 bits so a long transfer never aliases into the size
	always_comb begin
		if (remain > {20'h00000, active_size_q}) begin
			tx_len = active_size_q;
		end else begin
			tx_len = remain[11:0];
		end
		tx_last_flag = (remain <= {20'h00000, active_size_q});
		tx_valid     = (state_q == BEP_ST_BURST) && ctrl_q[BEP_CTRL_DIR_IN]
			&& (remain != 32'h0);
		tx_rate      = rate_q;
	end

	// one packet moved either way
	// an IN pipe ignores rx_valid and an OUT pipe never raises tx_valid
	always_comb begin
		if (ctrl_q[BEP_CTRL_DIR_IN]) begin
			pkt_move = tx_valid && tx_ready;
			pkt_len  = tx_len;
			pkt_last = tx_last_flag;
		end else begin
			// OUT accepts any length up to the active size
			pkt_move = rx_valid && (state_q == BEP_ST_BURST)
				&& (rx_len <= active_size_q);
			pkt_len  = rx_len;
			pkt_last = rx_last_flag;
		end
	end

	// one byte counter serves both directions
	bep_byte_count u_count (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.clear    (cfg_request_ok || xfer_done),
		.add      (pkt_move),
		.add_len  (pkt_len),
		.expected (xfer_len_q),
		.count_q  (moved),
		.reached  (count_hit)
	);

	// transfer completes on exact count or a last-flagged packet
	// a one-cycle pulse in the cycle of the final move
	always_comb begin
		xfer_done = pkt_move && (count_hit || pkt_last);
	end

	// window restart: a successful configuration request or the software strobe
	always_comb begin
		win_init = cfg_request_ok || ctrl_q[BEP_CTRL_INIT];
	end

	// pipe state machine
	// a configuration request wins over every other event, halt included
	always_ff @(posedge clk_sys) begin
		if (reset || cfg_request_ok) begin
			state_q <= BEP_ST_IDLE;
		end else begin
			case (state_q)
				BEP_ST_IDLE: begin
					// halt causes come before any token is looked at
					if (ctrl_q[BEP_CTRL_STALL] || retry_exhausted) begin
						state_q <= BEP_ST_HALT;
					end else if (tok_valid && !ctrl_q[BEP_CTRL_READY]) begin
						state_q <= BEP_ST_FLOW;  // nothing to move: flow control
					end else if (tok_accept) begin
						state_q <= BEP_ST_BURST;
					end
				end
				BEP_ST_BURST: begin
					// ends on completion or when the last granted packet moves
					if (retry_exhausted) begin
						state_q <= BEP_ST_HALT;
					end else if (xfer_done || (pkt_move && burst_left_q == 5'h01)) begin
						state_q <= BEP_ST_IDLE;
					end
				end
				BEP_ST_FLOW: begin
					// leave once data or space returns
					if (ctrl_q[BEP_CTRL_READY]) begin
						state_q <= BEP_ST_IDLE;
					end
				end
				BEP_ST_HALT: begin
					// held until a configuration request clears it
					// software alone cannot leave halt; the stall bit only enters it
					state_q <= BEP_ST_HALT;
				end
				default: begin
					// unreachable with one-hot codes; recovers a corrupted state
					state_q <= BEP_ST_IDLE;
				end
			endcase
		end
	end

	// burst parameters latched only when a token is accepted
	// so a new active size only takes hold at the start of a burst
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			active_size_q <= BEP_MAX_PAYLOAD;
			rate_q        <= 4'h0;
		end else if (tok_accept) begin
			active_size_q <= tok_size;
			rate_q        <= tok_rate;
		end
	end

	// burst countdown; a new token reloads it, every moved packet spends one
	always_ff @(posedge clk_sys) begin
		if (reset || cfg_request_ok) begin
			burst_left_q <= 5'h00;
		end else if (tok_accept) begin
			burst_left_q <= tok_burst;
		end else if (pkt_move) begin
			burst_left_q <= burst_left_q - 5'h01;
		end
	end

	// sequence window; restarts on a configuration request or the init strobe
	// the strobe only touches the window, so a burst in flight keeps its count
	always_ff @(posedge clk_sys) begin
		if (reset || win_init) begin
			seq_q <= 5'h00;
		end else if (pkt_move) begin
			// wrap below the reported maximum sequence value
			if (seq_q == BEP_MAX_SEQ - 5'h01) begin
				seq_q <= 5'h00;
			end else begin
				seq_q <= seq_q + 5'h01;
			end
		end
	end

	// IN bytes issued this transfer
	// only the IN side needs its own tally, for sizing the next packet
	always_ff @(posedge clk_sys) begin
		if (reset || cfg_request_ok || xfer_done) begin
			sent_q <= 32'h0;
		end else if (pkt_move && ctrl_q[BEP_CTRL_DIR_IN]) begin
			sent_q <= sent_q + {20'h00000, pkt_len};
		end
	end

	// ready notice owed after flow control; set wins over clear
	// the owed notice survives until ready returns or a configuration request clears it
	always_ff @(posedge clk_sys) begin
		if (reset || cfg_request_ok) begin
			flow_note_q <= 1'b0;
		end else if (state_q == BEP_ST_FLOW && !ctrl_q[BEP_CTRL_READY]) begin
			flow_note_q <= 1'b1;
		end else if (ep_ready_note) begin
			flow_note_q <= 1'b0;
		end
	end

	// handshake outputs
	// a halted pipe never sits in idle, so stall and flow never coincide
	always_comb begin
		hs_stall      = tok_valid && (state_q == BEP_ST_HALT);
		hs_flow_ctrl  = tok_valid && (state_q == BEP_ST_IDLE) && !ctrl_q[BEP_CTRL_READY];
		ep_ready_note = flow_note_q && ctrl_q[BEP_CTRL_READY];
	end

	// apb decode; zero wait states
	// pready is tied high; every access completes in its first access cycle
	always_comb begin
		wr_en   = psel && penable && pwrite;
		pready  = 1'b1;
		rd_hit  = (paddr <= BEP_REG_BUFLVL) && (paddr[1:0] == 2'h0);
		pslverr = psel && penable && !rd_hit;
	end

	// control register; init bit is a self-clearing strobe
	// a write replaces the whole word; upper bits read back as zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_q <= 32'h0;
		end else if (wr_en && paddr == BEP_REG_CTRL) begin
			ctrl_q <= {28'h0, pwdata[3:0]};
		end else begin
			ctrl_q[BEP_CTRL_INIT] <= 1'b0;
		end
	end

	// transfer length and buffer level
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			xfer_len_q <= 32'h0;
			buf_lvl_q  <= 32'h0;
		end else begin
			if (wr_en && paddr == BEP_REG_XFER) begin
				xfer_len_q <= pwdata;
			end
			if (wr_en && paddr == BEP_REG_BUFLVL) begin
				buf_lvl_q <= pwdata;
			end
		end
	end

	// register map, one aligned word each:
	//   0x00 control: direction, ready, init strobe, forced halt
	//   0x04 status: sequence, pipe state, ready notice owed
	//   0x08 expected transfer length in bytes
	//   0x0C bytes counted so far; restarts when a transfer completes
	//   0x10 capability word
	//   0x14 buffer level, kept for software only

	// read data registered on the setup cycle
	// settled before the access phase, at the cost of one flop per bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			case (paddr)
				BEP_REG_CTRL:   prdata <= ctrl_q;
				BEP_REG_STATUS: prdata <= {22'h0, seq_q, state_q, flow_note_q};
				BEP_REG_XFER:   prdata <= xfer_len_q;
				BEP_REG_DONE:   prdata <= moved;
				BEP_REG_CAPS:   prdata <= caps_word;
				BEP_REG_BUFLVL: prdata <= buf_lvl_q;
				default:        prdata <= 32'h0;
			endcase
		end
	end

endmodule : bep_bulk_endpoint

//--- testbench/bep_checker.sv
`timescale 1ns/1ns
// port watcher for the bulk endpoint
module bep_checker
	import bep_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        tok_valid,
	input wire logic [11:0] tok_size,
	input wire logic [3:0]  tok_rate,
	input wire logic        rx_valid,
	input wire logic        tx_ready,
	input wire logic        tx_valid,
	input wire logic [11:0] tx_len,
	input wire logic [3:0]  tx_rate,
	input wire logic        hs_stall,
	input wire logic        hs_flow_ctrl,
	input wire logic        ep_ready_note,
	input wire logic        xfer_done
);
	logic [11:0] size_q;  // active size of last token
	logic [3:0]  rate_q;  // directed rate of last token
	// illegal tokens are captured too, so a later legal one overwrites these
	always_ff @(posedge clk_sys) begin
		if (tok_valid) begin
			size_q <= tok_size;
			rate_q <= tok_rate;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// packet offered but held off
	sequence s_held_pkt;
		tx_valid && !tx_ready;
	endsequence
	a_rate_follow: assert property (tx_valid |-> tx_rate == rate_q)
		else $error("packet rate differs from token");
	a_size_cap: assert property (tx_valid |-> tx_len <= size_q)
		else $error("packet above active size");
	a_max_size: assert property (tx_valid |-> tx_len <= BEP_MAX_PAYLOAD)
		else $error("packet above largest payload");
	a_pkt_hold: assert property (s_held_pkt |=> tx_valid && $stable(tx_len) && $stable(tx_rate))
		else $error("held packet changed");
	a_done_cause: assert property (xfer_done |-> (tx_valid && tx_ready) || rx_valid)
		else $error("done without a packet");
	a_stall_tok: assert property (hs_stall |-> tok_valid && !hs_flow_ctrl)
		else $error("stall without token");
	a_stall_quiet: assert property (hs_stall |=> !tx_valid)
		else $error("halted pipe sends");
	a_flow_tok: assert property (hs_flow_ctrl |-> tok_valid ##1 !tx_valid)
		else $error("flow event misplaced");
	a_note_pulse: assert property (ep_ready_note |=> !ep_ready_note)
		else $error("ready notice too long");
	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("register access waited");
endmodule : bep_checker

bind bep_bulk_endpoint bep_checker bep_checker_i (.clk_sys(clk_sys), .reset(reset),
	.psel(psel), .penable(penable), .pready(pready),
	.tok_valid(tok_valid), .tok_size(tok_size), .tok_rate(tok_rate), .rx_valid(rx_valid),
	.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_len(tx_len), .tx_rate(tx_rate),
	.hs_stall(hs_stall), .hs_flow_ctrl(hs_flow_ctrl), .ep_ready_note(ep_ready_note),
	.xfer_done(xfer_done));

//--- testbench/bep_host_model.sv
`timescale 1ns/1ns
// host side: tokens, OUT packets, IN pacing
module bep_host_model
	import bep_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        stall_en,  // hold off IN packets at random
	output logic             tok_valid,
	output logic             tok_in,
	output logic [11:0]      tok_size,
	output logic [4:0]       tok_burst,
	output logic [3:0]       tok_rate,
	output logic             rx_valid,
	output logic [11:0]      rx_len,
	output logic             rx_last_flag,
	output logic             tx_ready
);
	// link quiet until the first token or packet
	initial begin
		tok_valid = 1'b0;
		tok_in = 1'b0;
		tok_size = 12'h000;
		tok_burst = 5'h00;
		tok_rate = 4'h0;
		rx_valid = 1'b0;
		rx_len = 12'h000;
		rx_last_flag = 1'b0;
	end
	// a slow host stalls about one cycle in three
	always @(posedge clk_sys) begin
		tx_ready <= !stall_en || ($urandom % 3 != 0);
	end
	// one token; fields are scrambled once released
	task automatic send_tok(input logic i, input logic [11:0] sz, input logic [4:0] bu,
			input logic [3:0] rt);
		@(posedge clk_sys);
		tok_valid <= 1'b1;
		tok_in <= i;
		tok_size <= sz;
		tok_burst <= bu;
		tok_rate <= rt;
		@(posedge clk_sys);
		tok_valid <= 1'b0;
		tok_size <= ~sz;
		tok_burst <= ~bu;
		tok_rate <= ~rt;
	endtask : send_tok
	// one OUT packet
	task automatic pkt(input logic [11:0] ln, input logic lf);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_len <= ln;
		rx_last_flag <= lf;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_len <= ~ln;
		rx_last_flag <= ~lf;
	endtask : pkt
endmodule : bep_host_model

//--- testbench/testbench.sv
`timescale 1ns/1ns
// bench: apb master, host model, scoreboard
module testbench;
	import bep_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        cfg_request_ok = 1'b0;
	logic        retry_exhausted = 1'b0;
	logic        stall_en = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, tok_valid, tok_in, rx_valid, rx_last_flag, tx_ready;
	logic        tx_valid, hs_stall, hs_flow_ctrl, ep_ready_note, xfer_done, seen, tx_last_flag;
	logic [11:0] tok_size, rx_len, tx_len;
	logic [4:0]  tok_burst;
	logic [3:0]  tok_rate, tx_rate, rate;
	logic [2:0]  unit;
	logic [17:0] pktq[$];  // len, last, done, rate
	logic [1:0]  tokq[$];  // stall, flow
	logic        rxq[$];   // done per OUT packet
	int          bad_count = 0;
	int          cmp_count = 0;

	always #10 clk_sys = ~clk_sys;

	bep_bulk_endpoint bep_bulk_endpoint_i (.clk_sys(clk_sys), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tok_valid(tok_valid), .tok_in(tok_in),
		.tok_size(tok_size), .tok_burst(tok_burst), .tok_rate(tok_rate),
		.cfg_request_ok(cfg_request_ok), .retry_exhausted(retry_exhausted),
		.rx_valid(rx_valid), .rx_len(rx_len), .rx_last_flag(rx_last_flag),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_len(tx_len), .tx_last_flag(tx_last_flag),
		.tx_rate(tx_rate), .hs_stall(hs_stall), .hs_flow_ctrl(hs_flow_ctrl),
		.ep_ready_note(ep_ready_note), .xfer_done(xfer_done));
	bep_host_model bep_host_model_i (.clk_sys(clk_sys), .stall_en(stall_en),
		.tok_valid(tok_valid), .tok_in(tok_in), .tok_size(tok_size), .tok_burst(tok_burst),
		.tok_rate(tok_rate), .rx_valid(rx_valid), .rx_len(rx_len),
		.rx_last_flag(rx_last_flag), .tx_ready(tx_ready));

	task automatic check(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : check
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	// one apb transfer; request held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, x);
		check(e, xe);
	endtask : rd
	task automatic cfg_pulse;
		@(posedge clk_sys);
		cfg_request_ok <= 1'b1;
		@(posedge clk_sys);
		cfg_request_ok <= 1'b0;
	endtask : cfg_pulse

	// scoreboard: each event takes the oldest note
	always @(posedge clk_sys) begin
		if (tok_valid === 1'b1) begin
			check({hs_stall, hs_flow_ctrl}, tokq.pop_front());
		end
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			check({tx_len, tx_last_flag, xfer_done, tx_rate}, pktq.pop_front());
		end
		if (rx_valid === 1'b1) begin
			check(xfer_done, rxq.pop_front());
		end
	end
	// watchdog at 3000 cycles; the run needs under a hundred cycles
	initial begin
		#(20 * 3000);
		bad_count++;
		stop_test();
	end
	initial begin
		void'($urandom(32'hDF4C));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(BEP_REG_STATUS, 32'h2, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		// IN: full packet then short remainder, host stalling
		unit = 3'($urandom % 7 + 1);
		rate = 4'($urandom % 4);
		wr(BEP_REG_XFER, (32'(unit) + 32'h1) << 9);
		wr(BEP_REG_CTRL, 32'h3);
		tokq.push_back(2'b00);
		bep_host_model_i.send_tok(1'b1, 12'h300, 5'h02, rate);
		tokq.push_back(2'b00);
		pktq.push_back({unit, 9'h000, 1'b0, 1'b0, rate});
		pktq.push_back({12'h200, 1'b1, 1'b1, rate});
		stall_en <= 1'b1;
		bep_host_model_i.send_tok(1'b1, {unit, 9'h000}, 5'h02, rate);
		for (int i = 0; i < 300 && pktq.size() > 0; i++) @(posedge clk_sys);
		stall_en <= 1'b0;
		// the byte tally restarts once a transfer completes
		rd(BEP_REG_DONE, 32'h0, 1'b0);
		// OUT with adjusted size, ended by the byte count
		wr(BEP_REG_CTRL, 32'h6);
		wr(BEP_REG_XFER, 32'h800);
		tokq.push_back(2'b00);
		bep_host_model_i.send_tok(1'b0, 12'h600, 5'h03, 4'h1);
		rxq.push_back(1'b0);
		rxq.push_back(1'b1);
		bep_host_model_i.pkt(12'h600, 1'b0);
		rd(BEP_REG_DONE, 32'h600, 1'b0);
		// ends on the byte count alone, last flag clear
		bep_host_model_i.pkt(12'h200, 1'b0);
		// flow control, then ready again
		wr(BEP_REG_CTRL, 32'h0);
		tokq.push_back(2'b01);
		bep_host_model_i.send_tok(1'b0, 12'h200, 5'h01, 4'h0);
		wr(BEP_REG_CTRL, 32'h2);
		seen = 1'b0;
		repeat (4) begin
			@(negedge clk_sys);
			seen = seen | (ep_ready_note === 1'b1);
		end
		check(seen, 1'b1);
		// halt by stall bit, sticky, then by retry exhaustion
		wr(BEP_REG_CTRL, 32'hA);
		tokq.push_back(2'b10);
		bep_host_model_i.send_tok(1'b0, 12'h200, 5'h01, 4'h0);
		wr(BEP_REG_CTRL, 32'h2);
		tokq.push_back(2'b10);
		bep_host_model_i.send_tok(1'b0, 12'h200, 5'h01, 4'h0);
		cfg_pulse();
		@(posedge clk_sys);
		retry_exhausted <= 1'b1;
		@(posedge clk_sys);
		retry_exhausted <= 1'b0;
		tokq.push_back(2'b10);
		bep_host_model_i.send_tok(1'b0, 12'h200, 5'h01, 4'h0);
		cfg_pulse();
		rd(BEP_REG_STATUS, 32'h2, 1'b0);
		tokq.push_back(2'b00);
		bep_host_model_i.send_tok(1'b0, 12'h400, 5'h01, 4'h2);
		// short packet ends this transfer by its last flag alone
		rxq.push_back(1'b1);
		bep_host_model_i.pkt(12'h200, 1'b1);
		repeat (4) @(posedge clk_sys);
		check(tokq.size() + pktq.size() + rxq.size(), 32'h0);
		stop_test();
	end
endmodule : testbench
